// >>> ppfm_top.sv
// Pin function multiplexer for ports T, S, M and P with the port T registers.
// Assumes pins arrive asynchronous, peripherals run on clk_i, and the
// GPIO controls of ports S and P come from their own register groups.
// Overview of operation
// - A shared pin goes to the enabled function of highest fixed priority.
// - Port T shows PWM only when routed; PWM beats timer beats GPIO.
// - After reset all port T pins are plain GPIO inputs.
// - Port S pin 1 carries serial transmit when active, else GPIO.
// - Port S pin 0 feeds serial receive when active; pins 3, 2 GPIO.
// - Port M pins 5..2 carry SPI lines, pins 1, 0 carry CAN lines.
// - Port P gives PWM priority, else GPIO with interrupt; pin 6 samples ROM enable.
// - Port T registers decode at indices 0 to 5 and 7, one bit per pin.
// - Routing register maps PWM onto port T; routed channels drive both ports.
//
// Register access over Wishbone was chosen for this implementation.
module ppfm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] port_t_pin_in_i,
  output logic [7:0] port_t_pin_out_o,
  output logic [7:0] port_t_pin_oe_o,
  output logic [7:0] port_t_drive_reduce_o,
  output logic [7:0] port_t_pull_enable_o,
  output logic [7:0] port_t_pull_select_o,
  input wire logic [7:0] timer_out_i,
  input wire logic [7:0] timer_out_en_i,
  output logic [7:0] timer_channel_pin_o,
  input wire logic [5:0] pwm_i,
  input wire logic [5:0] pwm_en_i,
  input wire logic [3:0] port_s_pin_in_i,
  output logic [3:0] port_s_pin_out_o,
  output logic [3:0] port_s_pin_oe_o,
  input wire logic [3:0] port_s_gpio_out_i,
  input wire logic [3:0] port_s_gpio_dir_i,
  output logic [3:0] port_s_level_o,
  input wire logic sci_tx_i,
  input wire logic sci_tx_en_i,
  input wire logic sci_rx_en_i,
  output logic sci_rx_o,
  input wire logic [5:0] port_m_pin_in_i,
  output logic [5:0] port_m_pin_out_o,
  output logic [5:0] port_m_pin_oe_o,
  input wire logic [3:0] spi_out_i,
  input wire logic [3:0] spi_oe_i,
  output logic [3:0] spi_in_o,
  input wire logic can_transmit_pin_i,
  output logic can_receive_pin_o,
  output logic [5:0] port_m_level_o,
  input wire logic [7:0] port_p_pin_in_i,
  output logic [7:0] port_p_pin_out_o,
  output logic [7:0] port_p_pin_oe_o,
  input wire logic [7:0] port_p_gpio_out_i,
  input wire logic [7:0] port_p_gpio_dir_i,
  output logic [7:0] port_p_level_o,
  output logic internal_rom_enable_input_o
);

  logic [ppfm_pkg::SYNC_W-1:0] sync1;
  logic [ppfm_pkg::SYNC_W-1:0] sync2;
  logic [7:0] port_t_data;
  logic [7:0] port_t_direction;
  logic [7:0] port_t_drive_reduce;
  logic [7:0] port_t_pull_enable;
  logic [7:0] port_t_pull_select;
  logic [4:0] pwm_route_to_port_t;
  logic ack;
  logic [31:0] rd_data;
  logic rom_enable;

  wire [7:0] t_level = sync2[25:18];
  wire [3:0] s_level = sync2[17:14];
  wire [5:0] m_level = sync2[13:8];
  wire [7:0] p_level = sync2[7:0];

  // Bus decode
  wire req = wb_cyc_i && wb_stb_i;
  wire [2:0] idx = wb_adr_i[4:2];
  wire wr_en = req && wb_we_i && ack && wb_sel_i[0];
  wire wr_data = wr_en && (idx == ppfm_pkg::IDX_DATA);
  wire wr_dir = wr_en && (idx == ppfm_pkg::IDX_DIR);
  wire wr_drive = wr_en && (idx == ppfm_pkg::IDX_DRIVE);
  wire wr_pull_en = wr_en && (idx == ppfm_pkg::IDX_PULL_EN);
  wire wr_pull_sel = wr_en && (idx == ppfm_pkg::IDX_PULL_SEL);
  wire wr_route = wr_en && (idx == ppfm_pkg::IDX_ROUTE);
  wire [7:0] wbyte = wb_dat_i[7:0];

  // Read selection, one byte per aligned word, upper bits zero
  logic [7:0] rd_byte;
  always_comb begin
    if (idx == ppfm_pkg::IDX_DATA) begin
      rd_byte = port_t_data;
    end else if (idx == ppfm_pkg::IDX_INPUT) begin
      rd_byte = t_level;
    end else if (idx == ppfm_pkg::IDX_DIR) begin
      rd_byte = port_t_direction;
    end else if (idx == ppfm_pkg::IDX_DRIVE) begin
      rd_byte = port_t_drive_reduce;
    end else if (idx == ppfm_pkg::IDX_PULL_EN) begin
      rd_byte = port_t_pull_enable;
    end else if (idx == ppfm_pkg::IDX_PULL_SEL) begin
      rd_byte = port_t_pull_select;
    end else if (idx == ppfm_pkg::IDX_ROUTE) begin
      rd_byte = {3'h0, pwm_route_to_port_t};
    end else begin
      rd_byte = 8'h00;
    end
  end
  assign rd_data = {24'h000000, rd_byte};

  // Two-stage synchroniser for every pin input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= ppfm_pkg::RST_SYNC;
      sync2 <= ppfm_pkg::RST_SYNC;
    end else begin
      sync1 <= {port_t_pin_in_i, port_s_pin_in_i, port_m_pin_in_i, port_p_pin_in_i};
      sync2 <= sync1;
    end
  end

  // Wishbone answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack <= req && !ack;
      if (req && !ack) begin
        wb_dat_o <= rd_data;
      end
    end
  end
  assign wb_ack_o = ack;

  // Port T registers; writes to the input level index are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_t_data <= ppfm_pkg::RST_PORT_T;
      port_t_direction <= ppfm_pkg::RST_PORT_T;
      port_t_drive_reduce <= ppfm_pkg::RST_PORT_T;
      port_t_pull_enable <= ppfm_pkg::RST_PORT_T;
      port_t_pull_select <= ppfm_pkg::RST_PORT_T;
      pwm_route_to_port_t <= ppfm_pkg::RST_ROUTE;
    end else begin
      if (wr_data) begin
        port_t_data <= wbyte;
      end
      if (wr_dir) begin
        port_t_direction <= wbyte;
      end
      if (wr_drive) begin
        port_t_drive_reduce <= wbyte;
      end
      if (wr_pull_en) begin
        port_t_pull_enable <= wbyte;
      end
      if (wr_pull_sel) begin
        port_t_pull_select <= wbyte;
      end
      if (wr_route) begin
        pwm_route_to_port_t <= wbyte[4:0];
      end
    end
  end

  // Pad controls follow the registers regardless of the selected function
  assign port_t_drive_reduce_o = port_t_drive_reduce;
  assign port_t_pull_enable_o = port_t_pull_enable;
  assign port_t_pull_select_o = port_t_pull_select;

  // Port T priority per pin: routed PWM, then timer, then GPIO
  logic [7:0] t_pwm_sel;
  logic [7:0] t_pwm_val;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_port_t
      if (gi < ppfm_pkg::PWM_T_W) begin : g_pwm
        assign t_pwm_sel[gi] = pwm_route_to_port_t[gi] && pwm_en_i[gi];
        assign t_pwm_val[gi] = pwm_i[gi];
      end else begin : g_nopwm
        assign t_pwm_sel[gi] = 1'b0;
        assign t_pwm_val[gi] = 1'b0;
      end
      assign port_t_pin_out_o[gi] = t_pwm_sel[gi] ? t_pwm_val[gi] :
                                    timer_out_en_i[gi] ? timer_out_i[gi] :
                                    port_t_data[gi];
      assign port_t_pin_oe_o[gi] = t_pwm_sel[gi] || timer_out_en_i[gi] ||
                                   port_t_direction[gi];
    end
  endgenerate
  assign timer_channel_pin_o = t_level;

  // Port S: serial transmit and receive over GPIO
  assign port_s_pin_out_o = {port_s_gpio_out_i[3:2],
                             sci_tx_en_i ? sci_tx_i : port_s_gpio_out_i[1],
                             port_s_gpio_out_i[0]};
  assign port_s_pin_oe_o = {port_s_gpio_dir_i[3:2],
                            sci_tx_en_i || port_s_gpio_dir_i[1],
                            !sci_rx_en_i && port_s_gpio_dir_i[0]};
  assign sci_rx_o = sci_rx_en_i ? s_level[ppfm_pkg::PS_SCI_RX] : 1'b1;
  assign port_s_level_o = s_level;

  // Port M: SPI on pins 5..2, CAN on pins 1, 0
  assign port_m_pin_out_o = {spi_out_i, can_transmit_pin_i, 1'b0};
  assign port_m_pin_oe_o = {spi_oe_i, 1'b1, 1'b0};
  assign spi_in_o = m_level[5:2];
  assign can_receive_pin_o = m_level[ppfm_pkg::PM_CAN_RX];
  assign port_m_level_o = m_level;

  // Port P: PWM over GPIO; levels feed the pin interrupt logic
  wire [7:0] p_pwm_sel = {2'h0, pwm_en_i};
  wire [7:0] p_pwm_val = {2'h0, pwm_i};
  assign port_p_pin_out_o = (p_pwm_sel & p_pwm_val) | (~p_pwm_sel & port_p_gpio_out_i);
  assign port_p_pin_oe_o = p_pwm_sel | port_p_gpio_dir_i;
  assign port_p_level_o = p_level;

  // Strap synchroniser runs through reset; the main one is held at zero there
  logic strap_sync1;
  logic strap_sync2;
  always_ff @(posedge clk_i) begin
    strap_sync1 <= port_p_pin_in_i[ppfm_pkg::PP_ROM_PIN];
    strap_sync2 <= strap_sync1;
  end

  // ROM enable strap caught while reset is held, kept after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rom_enable <= strap_sync2;
    end
  end
  assign internal_rom_enable_input_o = rom_enable;

  // Checks: port T reset, priority and input sync
  a_reset_gpio: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> pwm_route_to_port_t == 5'h00 && port_t_direction == 8'h00)
    else $error("port T not GPIO input after reset");
  a_pwm_over_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_route_to_port_t[0] && pwm_en_i[0] && timer_out_en_i[0] |->
    port_t_pin_out_o[0] == pwm_i[0] && port_t_pin_oe_o[0])
    else $error("routed PWM lost to timer on port T");
  a_timer_over_gpio: assert property (@(posedge clk_i) disable iff (rst_i)
    !t_pwm_sel[7] && timer_out_en_i[7] |->
    port_t_pin_out_o[7] == timer_out_i[7] && port_t_pin_oe_o[7])
    else $error("timer lost to GPIO on port T");
  a_unrouted_gpio: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwm_route_to_port_t[1] && !timer_out_en_i[1] |->
    port_t_pin_out_o[1] == port_t_data[1] && port_t_pin_oe_o[1] == port_t_direction[1])
    else $error("unrouted PWM reached port T");
  a_unrouted_timer: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwm_route_to_port_t[2] && timer_out_en_i[2] |->
    port_t_pin_out_o[2] == timer_out_i[2] && port_t_pin_oe_o[2])
    else $error("unrouted pin not given to the timer");
  a_no_pwm_high: assert property (@(posedge clk_i) disable iff (rst_i)
    !timer_out_en_i[5] |->
    port_t_pin_out_o[5] == port_t_data[5] && port_t_pin_oe_o[5] == port_t_direction[5])
    else $error("port T pin 5 left GPIO without cause");
  a_route_both: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_route_to_port_t[3] && pwm_en_i[3] |->
    port_t_pin_out_o[3] == pwm_i[3] && port_p_pin_out_o[3] == pwm_i[3])
    else $error("routed PWM not on both ports");
  a_input_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(rst_i, 2) |->
    timer_channel_pin_o == $past(port_t_pin_in_i, 2))
    else $error("port T level not two cycles behind the pin");

  // Checks: ports S, M and P
  a_sci_tx_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    sci_tx_en_i |-> port_s_pin_out_o[1] == sci_tx_i && port_s_pin_oe_o[1])
    else $error("serial transmit not on port S pin 1");
  a_sci_tx_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !sci_tx_en_i |->
    port_s_pin_out_o[1] == port_s_gpio_out_i[1] && port_s_pin_oe_o[1] == port_s_gpio_dir_i[1])
    else $error("port S pin 1 GPIO fallback wrong");
  a_sci_rx_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    sci_rx_en_i |-> !port_s_pin_oe_o[0] && sci_rx_o == s_level[0])
    else $error("serial receive pin misdriven");
  a_sci_rx_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !sci_rx_en_i |-> sci_rx_o && port_s_pin_oe_o[0] == port_s_gpio_dir_i[0])
    else $error("port S pin 0 GPIO fallback wrong");
  a_s_gpio_only: assert property (@(posedge clk_i) disable iff (rst_i)
    port_s_pin_out_o[3:2] == port_s_gpio_out_i[3:2] &&
    port_s_pin_oe_o[3:2] == port_s_gpio_dir_i[3:2])
    else $error("port S pins 3 and 2 not plain GPIO");
  a_spi_can_map: assert property (@(posedge clk_i) disable iff (rst_i)
    port_m_pin_out_o[5:1] == {spi_out_i, can_transmit_pin_i} && !port_m_pin_oe_o[0])
    else $error("port M function map wrong");
  a_port_p_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_en_i[5] |-> port_p_pin_out_o[5] == pwm_i[5] && port_p_pin_oe_o[5])
    else $error("PWM lost on port P");
  a_p_gpio_fallback: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwm_en_i[0] |->
    port_p_pin_out_o[0] == port_p_gpio_out_i[0] && port_p_pin_oe_o[0] == port_p_gpio_dir_i[0])
    else $error("port P GPIO fallback wrong");
  a_strap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> $stable(internal_rom_enable_input_o))
    else $error("ROM enable strap changed outside reset");

  // Checks: bus and registers
  a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && wb_we_i && wb_sel_i[0] && idx == ppfm_pkg::IDX_DIR |=>
    port_t_direction == $past(wb_dat_i[7:0]))
    else $error("direction write not stored");
  a_data_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && wb_we_i && wb_sel_i[0] && idx == ppfm_pkg::IDX_DATA |=>
    port_t_data == $past(wb_dat_i[7:0]))
    else $error("data write not stored");
  a_route_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && wb_we_i && wb_sel_i[0] && idx == ppfm_pkg::IDX_ROUTE |=>
    pwm_route_to_port_t == $past(wb_dat_i[4:0]))
    else $error("routing write not stored");
  a_sel_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && wb_we_i && !wb_sel_i[0] |=>
    $stable(port_t_data) && $stable(port_t_direction) && $stable(pwm_route_to_port_t))
    else $error("write with low byte lane disabled changed a register");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && idx == ppfm_pkg::IDX_RESERVED |-> wb_dat_o == 32'h00000000)
    else $error("reserved index read not zero");
  a_input_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && idx == ppfm_pkg::IDX_INPUT |->
    wb_dat_o == {24'h000000, $past(t_level)})
    else $error("input level read wrong");

  // Main scenarios
  c_route_write: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_route ##1 pwm_route_to_port_t != 5'h00);
  c_input_read: cover property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && idx == ppfm_pkg::IDX_INPUT);
  c_pwm_on_t: cover property (@(posedge clk_i) disable iff (rst_i)
    t_pwm_sel[0] && timer_out_en_i[0]);
  c_strap_set: cover property (@(posedge clk_i)
    $past(rst_i) && !rst_i && internal_rom_enable_input_o);
  c_sci_both: cover property (@(posedge clk_i) disable iff (rst_i)
    sci_rx_en_i && sci_tx_en_i);

endmodule

// >>> ppfm_pkg.sv
// Constants for the port pin function multiplexer.
// Assumes a 32-bit classic Wishbone slave with registers one per aligned word.
package ppfm_pkg;
  localparam int unsigned PT_W = 8;
  localparam int unsigned PS_W = 4;
  localparam int unsigned PM_W = 6;
  localparam int unsigned PP_W = 8;
  localparam int unsigned PWM_T_W = 5;
  localparam int unsigned PWM_P_W = 6;
  localparam int unsigned SYNC_W = PT_W + PS_W + PM_W + PP_W;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_INPUT = 3'h1;
  localparam logic [2:0] IDX_DIR = 3'h2;
  localparam logic [2:0] IDX_DRIVE = 3'h3;
  localparam logic [2:0] IDX_PULL_EN = 3'h4;
  localparam logic [2:0] IDX_PULL_SEL = 3'h5;
  localparam logic [2:0] IDX_RESERVED = 3'h6;
  localparam logic [2:0] IDX_ROUTE = 3'h7;
  // Values after reset
  localparam logic [7:0] RST_PORT_T = 8'h00;
  localparam logic [4:0] RST_ROUTE = 5'h00;
  localparam logic [SYNC_W-1:0] RST_SYNC = 26'h0000000;
  // Port M pin positions
  localparam int unsigned PM_SPI_LO = 2;
  localparam int unsigned PM_CAN_TX = 1;
  localparam int unsigned PM_CAN_RX = 0;
  // Port P pin sampled for the internal ROM enable
  localparam int unsigned PP_ROM_PIN = 6;
  // Port S pin positions
  localparam int unsigned PS_SCI_TX = 1;
  localparam int unsigned PS_SCI_RX = 0;
endpackage

// >>> ppfm_pin_model.sv
// Partner model: the wiring and outside devices on one port's pins.
// Assumes the block gives drive value and enable; ext_i is the outside drive.
module ppfm_pin_model #(parameter int unsigned W = 8) (
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] ext_i,
  output logic [W-1:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins follow the block, released pins follow the outside device
  assign level_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// >>> port_pin_function_mux_tb.sv
// Self-checking bench for the pin function multiplexer.
// Assumes ppfm_top, ppfm_pin_model, a 100 MHz clock and Wishbone classic.
module port_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i, wsel;
  logic [31:0] wb_dat_i, wb_dat_o, q, r;
  logic [7:0] tin, tout, toe, tdr, tpe, tps, tmr, tmr_en, tch, pin, pout, poe, pgo, pgd, plv;
  logic [5:0] pwm, pwm_en, min, mout, moe, mlv, ext_m;
  logic [3:0] sin, sout, soe, sgo, sgd, slv, spo, spe, spi, ext_s;
  logic [7:0] ext_t, ext_p, wd;
  logic [1:0] pad;
  logic sci_tx, sci_tx_en, sci_rx_en, sci_rx, can_tx, can_rx, rom;
  logic [7:0] rg [0:7];
  logic [2:0] tab [0:7] = '{3'h7, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h6};
  integer seed, errors, checked, k;

  ppfm_top ppfm_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_t_pin_in_i(tin), .port_t_pin_out_o(tout),
    .port_t_pin_oe_o(toe), .port_t_drive_reduce_o(tdr), .port_t_pull_enable_o(tpe),
    .port_t_pull_select_o(tps), .timer_out_i(tmr), .timer_out_en_i(tmr_en),
    .timer_channel_pin_o(tch), .pwm_i(pwm), .pwm_en_i(pwm_en), .port_s_pin_in_i(sin),
    .port_s_pin_out_o(sout), .port_s_pin_oe_o(soe), .port_s_gpio_out_i(sgo),
    .port_s_gpio_dir_i(sgd), .port_s_level_o(slv), .sci_tx_i(sci_tx), .sci_tx_en_i(sci_tx_en),
    .sci_rx_en_i(sci_rx_en), .sci_rx_o(sci_rx), .port_m_pin_in_i(min), .port_m_pin_out_o(mout),
    .port_m_pin_oe_o(moe), .spi_out_i(spo), .spi_oe_i(spe), .spi_in_o(spi),
    .can_transmit_pin_i(can_tx), .can_receive_pin_o(can_rx), .port_m_level_o(mlv),
    .port_p_pin_in_i(pin), .port_p_pin_out_o(pout), .port_p_pin_oe_o(poe),
    .port_p_gpio_out_i(pgo), .port_p_gpio_dir_i(pgd), .port_p_level_o(plv),
    .internal_rom_enable_input_o(rom));
  ppfm_pin_model #(.W(8)) t_pins (.out_i(tout), .oe_i(toe), .ext_i(ext_t), .level_o(tin));
  ppfm_pin_model #(.W(4)) s_pins (.out_i(sout), .oe_i(soe), .ext_i(ext_s), .level_o(sin));
  ppfm_pin_model #(.W(6)) m_pins (.out_i(mout), .oe_i(moe), .ext_i(ext_m), .level_o(min));
  ppfm_pin_model #(.W(8)) p_pins (.out_i(pout), .oe_i(poe), .ext_i(ext_p), .level_o(pin));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [15:0] exp_t(input logic [7:0] d, dir, ten, tv, rt,
                                        input logic [5:0] pe, pv);
    logic [7:0] pm, tm, gm;
    pm = {3'h0, rt[4:0] & pe[4:0]};
    tm = ten & ~pm;
    gm = ~(pm | tm);
    return {pm | tm | (gm & dir), (pm & {2'h0, pv}) | (tm & tv) | (gm & d)};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("Checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [2:0] idx, input logic [7:0] d,
                    input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic do_reset(input logic s);
    int i;
    @(posedge clk_i);
    rst_i <= 1'b1;
    ext_p <= {1'b0, s, 6'h0};
    pgd <= 8'h0;
    tmr_en <= 8'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++) rg[i] = 8'h0;
    @(posedge clk_i);
    #1;
    chk("rom", rom, s);
    chk("t_oe_rst", toe, 8'h0);
    for (i = 0; i < 8; i++) begin
      wb(1'b0, i[2:0], 8'h0, 4'hf);
      if (i != 1) chk("rst_reg", q, 32'h0);
      else chk("rst_in", q, {24'h0, tin});
    end
    $display("reset test with strap %0d done", s);
  endtask

  task automatic rnd(input int n);
    @(posedge clk_i);
    r = $random(seed);
    {tmr, tmr_en, pgo, pgd} <= r | {8'h00, {8{n < 2}}, 16'h0};
    r = $random(seed);
    {pwm, pwm_en, sgo, sgd, spo, spe, sci_tx, sci_tx_en, sci_rx_en, can_tx} <=
      r | {6'h0, {6{n < 2}}, 20'h0};
    r = $random(seed);
    {ext_t, ext_p, ext_m, ext_s} <= r[31:6];
    {wsel, pad} = r[5:0];
  endtask

  task automatic check_pins;
    logic [15:0] e;
    logic [7:0] pm;
    logic [3:0] sm;
    e = exp_t(rg[0], rg[2], tmr_en, tmr, rg[7], pwm_en, pwm);
    pm = {2'h0, pwm_en};
    sm = {2'h0, sci_tx_en, 1'b0};
    chk("t_oe", toe, e[15:8]);
    chk("t_out", tout & toe, e[7:0] & e[15:8]);
    chk("t_cfg", {tdr, tpe, tps}, {rg[3], rg[4], rg[5]});
    chk("p_oe", poe, pm | pgd);
    chk("p_out", pout & poe, ((pm & {2'h0, pwm}) | (~pm & pgo)) & poe);
    chk("s_oe", soe, sm | (~sm & ~{3'h0, sci_rx_en} & sgd));
    chk("s_out", sout & soe, ((sm & {4{sci_tx}}) | (~sm & sgo)) & soe);
    chk("m_oe", moe, {spe, 2'b10});
    chk("m_out", mout & moe, {spo, can_tx, 1'b0} & moe);
    chk("sync", {slv, mlv, plv, tch}, {sin, min, pin, tin});
    chk("rx", {sci_rx, can_rx, spi}, {sci_rx_en ? sin[0] : 1'b1, min[0], min[5:2]});
  endtask

  initial begin
    seed = 32'hfdf2;
    errors = 0;
    checked = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {tmr, tmr_en, pgo, pgd, pwm, pwm_en, sgo, sgd, spo, spe} = '0;
    {sci_tx, sci_tx_en, sci_rx_en, can_tx, ext_t, ext_p, ext_m, ext_s, wsel} = '0;
    do_reset(1'b1);
    for (k = 0; k < 40; k++) begin
      rnd(k);
      r = $random(seed);
      wd = (k == 0) ? 8'hff : r[7:0];
      wb(1'b1, tab[k % 8], wd, wsel | {3'h0, k < 8});
      if (tab[k % 8] != 1 && tab[k % 8] != 6 && (wsel[0] || k < 8))
        rg[tab[k % 8]] = (tab[k % 8] == 7) ? (wd & 8'h1f) : wd;
      repeat (3) @(posedge clk_i);
      wb(1'b0, tab[k % 8], 8'h0, 4'hf);
      chk("rd", q, {24'h0, (tab[k % 8] == 1) ? tin : rg[tab[k % 8]]});
      #1;
      check_pins;
      $display("test %0d done", k);
    end
    do_reset(1'b0);
    results;
  end

  initial begin
    #100000;
    errors++;
    results;
  end
endmodule
